// ==== design/sctg_pkg.sv ====
/*
 * Constants and carrier types of the serial cycle timing generator.
 * Assumes a 10 MHz system clock and a free-running 2.048 MHz oscillator
 * square wave arriving on a pin from outside the clock domain.
 */
// Contract
// - Computer cycle lasts about 82 microseconds
// - Three equal phases A, B, C per cycle
// - Phase A instruction time, B and C operation
// - Each phase holds 14 equal bit times
// - One 14-bit syllable per phase
// - Three syllables per computer cycle
// - Four clock slots per bit, fixed order
// - Clock generator divides source by four
// - Seven gates with complements mark 14 bits
// - Phase generator divides gate rate by three
// - Slots recur 512 kHz, delay clock 2.048 MHz
// - Complementary squares: inverted drives delay lines
// - Decoded strobes from phase, bit, slot
// - Buffer, dividers, drivers in three channels
// - Four source clocks per bit, 512 kbit/s
package sctg_pkg;

    // ************************************************************
    // Counts and rates
    // ************************************************************
    localparam int NUM_CHAN     = 3;
    localparam int NUM_SLOTS    = 4;
    localparam int NUM_GATES    = 7;
    localparam int BITS_PER_PH  = 14;
    localparam int NUM_PHASES   = 3;
    localparam int OSC_KHZ      = 2048;
    localparam int MCLK_KHZ     = 10000;
    localparam int CYCLE_US_NOM = 82;
    // Exact cycle length in ns from the divider chain: 82031
    localparam int CYCLE_NS     = (NUM_PHASES * BITS_PER_PH * NUM_SLOTS * 1000000) / OSC_KHZ;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [3:0] SLOT_RST  = 4'h1;
    localparam logic [6:0] GATE_RST  = 7'h00;
    localparam logic [6:0] GATE_LAST = 7'h40;
    localparam logic [2:0] PHASE_RST = 3'h1;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] osc_sync;
        logic       osc_prev;
        logic       feed;
        logic       dl_clk;
        logic [3:0] slot;
        logic [6:0] gate;
        logic [2:0] phase;
        logic       strobe_pbs;
        logic       strobe_bs;
    } sctg_chan_t;

    typedef struct packed {
        logic [1:0] phase_sel;
        logic [3:0] bit_sel;
        logic [1:0] slot_sel;
    } sctg_strobe_sel_t;

    typedef sctg_chan_t [NUM_CHAN-1:0] sctg_state_t;

endpackage

// ==== design/sctg_top.sv ====
/*
 * Triple-channel timing generator: slot, gate and phase dividers.
 * Assumes osc_i is an unsynchronised 2.048 MHz square wave and that
 * sync_clr_i and strobe_sel_i come from logic on mclk_i.
 */
`timescale 1ns/10ps
module sctg_top (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       osc_i,
    input  wire logic                       sync_clr_i,
    input  wire sctg_pkg::sctg_strobe_sel_t strobe_sel_i,
    output logic [2:0]                      divider_feed_square_o,
    output logic [2:0]                      delay_line_drive_clock_o,
    output logic [2:0][3:0]                 slot_o,
    output logic [2:0][6:0]                 gate_o,
    output logic [2:0][2:0]                 phase_o,
    output logic [2:0]                      instr_time_o,
    output logic [2:0]                      strobe_pbs_o,
    output logic [2:0]                      strobe_bs_o
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Bit time 1..14 from the twisted-ring gate pattern
    function automatic logic [3:0] gate_bit(input logic [6:0] g);
        logic [3:0] ones;
        ones = 4'h0;
        for (int i = 0; i < sctg_pkg::NUM_GATES; i++) begin
            ones = ones + {3'h0, g[i]};
        end
        if (g[0] || (g == sctg_pkg::GATE_RST)) begin
            gate_bit = ones + 4'h1;
        end else begin
            gate_bit = 4'hf - ones;
        end
    endfunction

    function automatic logic [1:0] onehot_idx(input logic [3:0] v);
        onehot_idx = {v[3] | v[2], v[3] | v[1]};
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    sctg_pkg::sctg_state_t st_r;
    sctg_pkg::sctg_state_t st_nxt;

    always_comb begin
        logic       tick;
        logic       last_bit;
        logic [3:0] nbit;
        tick     = 1'b0;
        last_bit = 1'b0;
        nbit     = 4'h0;
        st_nxt   = st_r;
        // Each channel has its own buffer and dividers
        for (int c = 0; c < sctg_pkg::NUM_CHAN; c++) begin
            st_nxt[c].osc_sync = {st_r[c].osc_sync[0], osc_i};
            st_nxt[c].osc_prev = st_r[c].osc_sync[1];
            // Complementary squares at the source rate
            st_nxt[c].feed     = st_r[c].osc_sync[1];
            st_nxt[c].dl_clk   = ~st_r[c].osc_sync[1];
            tick     = st_r[c].osc_sync[1] & ~st_r[c].osc_prev;
            last_bit = st_r[c].gate == sctg_pkg::GATE_LAST;
            if (sync_clr_i) begin
                // Hold at A, bit 1, W; first rising source edge moves on
                st_nxt[c].slot  = sctg_pkg::SLOT_RST;
                st_nxt[c].gate  = sctg_pkg::GATE_RST;
                st_nxt[c].phase = sctg_pkg::PHASE_RST;
            end else if (tick) begin
                // Divide source by four, W X Y Z in order
                st_nxt[c].slot = {st_r[c].slot[2:0], st_r[c].slot[3]};
                if (st_r[c].slot[3]) begin
                    // Seven-stage twisted ring: 14 bit times
                    st_nxt[c].gate = {st_r[c].gate[5:0], ~st_r[c].gate[6]};
                    if (last_bit) begin
                        // Divide by three: A B C, one syllable each
                        st_nxt[c].phase = {st_r[c].phase[1:0], st_r[c].phase[2]};
                    end
                end
            end
            // Strobes decoded from next state so they align with it
            nbit = gate_bit(st_nxt[c].gate);
            st_nxt[c].strobe_bs = (nbit == strobe_sel_i.bit_sel)
                && (onehot_idx(st_nxt[c].slot) == strobe_sel_i.slot_sel);
            st_nxt[c].strobe_pbs = st_nxt[c].strobe_bs
                && (onehot_idx({1'b0, st_nxt[c].phase}) == strobe_sel_i.phase_sel);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int c = 0; c < sctg_pkg::NUM_CHAN; c++) begin
                st_r[c].osc_sync   <= 2'h0;
                st_r[c].osc_prev   <= 1'b0;
                st_r[c].feed       <= 1'b0;
                st_r[c].dl_clk     <= 1'b1;
                st_r[c].slot       <= sctg_pkg::SLOT_RST;
                st_r[c].gate       <= sctg_pkg::GATE_RST;
                st_r[c].phase      <= sctg_pkg::PHASE_RST;
                st_r[c].strobe_pbs <= 1'b0;
                st_r[c].strobe_bs  <= 1'b0;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Channels kept apart; voting belongs to the consumers
    always_comb begin
        for (int c = 0; c < sctg_pkg::NUM_CHAN; c++) begin
            divider_feed_square_o[c]    = st_r[c].feed;
            delay_line_drive_clock_o[c] = st_r[c].dl_clk;
            slot_o[c]                   = st_r[c].slot;
            gate_o[c]                   = st_r[c].gate;
            phase_o[c]                  = st_r[c].phase;
            instr_time_o[c]             = st_r[c].phase[0];  // Phase A
            strobe_pbs_o[c]             = st_r[c].strobe_pbs;
            strobe_bs_o[c]              = st_r[c].strobe_bs;
        end
    end

endmodule // sctg_top

// ==== sim/sctg_chk.sv ====
/* Assertion checker for the timing generator outputs.
   Assumes it is bound to sctg_top and sees only its ports. */
`timescale 1ns/10ps
module sctg_chk (
    input wire logic                       mclk_i,
    input wire logic                       rst_n_i,
    input wire logic                       sync_clr_i,
    input wire sctg_pkg::sctg_strobe_sel_t strobe_sel_i,
    input wire logic [2:0]                 divider_feed_square_o,
    input wire logic [2:0]                 delay_line_drive_clock_o,
    input wire logic [2:0][3:0]            slot_o,
    input wire logic [2:0][6:0]            gate_o,
    input wire logic [2:0][2:0]            phase_o,
    input wire logic [2:0]                 instr_time_o,
    input wire logic [2:0]                 strobe_pbs_o,
    input wire logic [2:0]                 strobe_bs_o
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_inv; delay_line_drive_clock_o == ~divider_feed_square_o; endproperty
    a_inv: assert property (p_inv) else $error("drive clock not inverse");
    property p_tmr;
        {slot_o[1], gate_o[1], phase_o[1]} == {slot_o[0], gate_o[0], phase_o[0]}
        && {slot_o[2], gate_o[2], phase_o[2]} == {slot_o[0], gate_o[0], phase_o[0]}
        && strobe_pbs_o[1] == strobe_pbs_o[0] && strobe_pbs_o[2] == strobe_pbs_o[0]
        && strobe_bs_o[1] == strobe_bs_o[0] && strobe_bs_o[2] == strobe_bs_o[0];
    endproperty
    a_tmr: assert property (p_tmr) else $error("channels differ");
    property p_order; $changed(slot_o[0]) && !$past(sync_clr_i)
        |-> slot_o[0] == {$past(slot_o[0][2:0]), $past(slot_o[0][3])}; endproperty
    a_order: assert property (p_order) else $error("slot order broken");
    property p_gate; $changed(gate_o[0]) && !$past(sync_clr_i)
        |-> $past(slot_o[0][3]) && slot_o[0][0]; endproperty
    a_gate: assert property (p_gate) else $error("gate step off Z to W");
    property p_phase; $changed(phase_o[0]) && !$past(sync_clr_i)
        |-> $past(gate_o[0]) == 7'h40 && gate_o[0] == 7'h00; endproperty
    a_phase: assert property (p_phase) else $error("phase step misplaced");
    property p_instr; instr_time_o[0] == phase_o[0][0]; endproperty
    a_instr: assert property (p_instr) else $error("instruction time wrong");
    property p_clr; sync_clr_i
        |=> slot_o[0] == 4'h1 && gate_o[0] == 7'h00 && phase_o[0] == 3'h1; endproperty
    a_clr: assert property (p_clr) else $error("clear not honoured");
    // Osc period is near five clocks, so a slot stands at least four
    property p_len; $changed(slot_o[0]) && !$past(sync_clr_i)
        |=> ($stable(slot_o[0]) || $past(sync_clr_i)) [*3]; endproperty
    a_len: assert property (p_len) else $error("slot too short");
    property p_strb; !sync_clr_i && strobe_pbs_o[0] |-> strobe_bs_o[0]
        && phase_o[0][strobe_sel_i.phase_sel] && slot_o[0][strobe_sel_i.slot_sel]; endproperty
    a_strb: assert property (p_strb) else $error("strobe off select");
    c_phc: cover property (phase_o[0] == 3'h4);
    c_pbs: cover property (strobe_pbs_o[0]);
    c_clr: cover property (sync_clr_i);
endmodule // sctg_chk
bind sctg_top sctg_chk i_sctg_chk (.mclk_i, .rst_n_i, .sync_clr_i, .strobe_sel_i,
    .divider_feed_square_o, .delay_line_drive_clock_o, .slot_o, .gate_o, .phase_o,
    .instr_time_o, .strobe_pbs_o, .strobe_bs_o);

// ==== sim/sctg_osc.sv ====
/* Oscillator model: free-running square wave at 2.048 MHz.
   Assumes no phase relation to the system clock. */
`timescale 1ns/10ps
module sctg_osc (
    output logic osc_o
);
    initial begin
        osc_o = 1'b0;
        #37.3;
        forever #244.14 osc_o = ~osc_o;
    end
endmodule // sctg_osc

// ==== sim/test_serial_cycle_timing_gen.sv ====
/* Self-checking bench: counter model against channel 0 outputs.
   Assumes the checker is bound and the oscillator model runs free. */
`timescale 1ns/10ps
module test_serial_cycle_timing_gen;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, sync_clr_i = 1'b0, osc_i, pc = 1'b0, m;
    sctg_pkg::sctg_strobe_sel_t sel = '0;
    logic [2:0] fs, dl, it, sp, sb;
    logic [2:0][3:0] sl;
    logic [2:0][6:0] gt;
    logic [2:0][2:0] ph;
    logic [3:0] ls = 4'h1;
    int bad_count = 0, num_checks = 0, s = 0, b = 1, p = 0, no = 0, ns = 0;
    always #50 mclk_i = ~mclk_i;
    sctg_osc i_sctg_osc (.osc_o(osc_i));
    sctg_top i_sctg_top (.mclk_i, .rst_n_i, .osc_i, .sync_clr_i, .strobe_sel_i(sel),
        .divider_feed_square_o(fs), .delay_line_drive_clock_o(dl), .slot_o(sl),
        .gate_o(gt), .phase_o(ph), .instr_time_o(it), .strobe_pbs_o(sp), .strobe_bs_o(sb));
    task chk(input logic [31:0] v, input logic [31:0] e);
        num_checks++;
        if (v !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, v, e);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    function automatic logic [6:0] g(int n);
        return n <= 8 ? 7'h7f >> (8 - n) : 7'h7f << (n - 8);
    endfunction
    // ****************************************
    // Model, advanced on every slot step
    // ****************************************
    always @(posedge osc_i) no++;
    always @(posedge mclk_i) if (rst_n_i) begin
        #1;
        if (pc) begin s = 0; b = 1; p = 0; end
        else if (sl[0] !== ls) begin
            ns++;
            s = (s + 1) % 4;
            if (s == 0) begin b = b % 14 + 1; if (b == 1) p = (p + 1) % 3; end
        end
        ls = sl[0];
        m = (b == sel.bit_sel) && (s == sel.slot_sel);
        chk({sl[0], gt[0], ph[0], it[0]}, {4'h1 << s, g(b), 3'h1 << p, p == 0});
        // Skip the edge where a new select lands; the strobe flop still holds the old one
        if (!pc && !sync_clr_i) chk({sb[0], sp[0]}, {m, m && (p == sel.phase_sel)});
        pc = sync_clr_i;
    end
    initial begin #1ms; bad_count++; report_and_stop; end
    initial begin
        void'($urandom(19899));
        repeat (2) @(posedge mclk_i);
        #1 chk({fs[0], dl[0], sl[0], ph[0], it[0], sb[0], sp[0]}, 12'h44c);
        @(posedge mclk_i) rst_n_i <= 1'b1;
        for (int t = 0; t < 4; t++) begin
            @(posedge mclk_i);
            sync_clr_i <= 1'b1;
            sel <= '{2'($urandom_range(2)), 4'($urandom_range(14, 1)), 2'($urandom)};
            repeat ($urandom_range(5, 1)) @(posedge mclk_i);
            sync_clr_i <= 1'b0;
            no = 0;
            ns = 0;
            repeat (900) @(posedge mclk_i);
            chk((no - ns) * (no - ns) <= 1, 32'h1);
            $display("test %0d done", t);
        end
        report_and_stop;
    end
endmodule // test_serial_cycle_timing_gen
